// ==== design/gpcb_pkg.sv ====
// Constants, register map and field layouts of the pin configuration bank.
// Assumes an APB master on pclk and pads resolved outside the design.
// How it works
// - Bit 0 of each configuration register makes the pin an input when set and an output when clear.
// - Bit 1 inverts the pin value when set and passes it straight through when clear.
// - Bit 7 selects an open-drain driver when set and a push-pull driver when clear.
// - On pin 2.5 bit 2 hands the pin to keyboard controller port line two; bits 6 to 3 are reserved.
// - Pin 2.6 has no alternate function, so bits 6 to 2 of its register are reserved.
// - On pin 2.7 bit 2 puts the system management interrupt output on the pin.
// - On pin 3.0 bit 2 makes the pin the active-low expansion chip select two.
// - On pin 3.1 bit 2 makes the pin the active-low expansion chip select three.
// - On pin 3.2 bit 2 routes the pin to the fan rotation pulse input.
// - On pin 3.3 bit 2 drives the fan speed output; the register loads 0x01 on standby power-on and 0x00 on main power-on or bus reset.
// - On pin 3.4 bit 2 makes the pin interrupt request input A.
// - On pin 3.5 bit 2 makes the pin interrupt request input B.
// - On pin 3.6 bit 2 drives the active-low keyboard reset onto the pin.
// - Every configuration register loads 0x01 on standby power-on, a plain non-inverted push-pull input.
package gpcb_pkg;

    localparam int PIN_COUNT = 10;

    // Pin positions in every pin-wide vector
    localparam int PIN_2_5 = 0;
    localparam int PIN_2_6 = 1;
    localparam int PIN_2_7 = 2;
    localparam int PIN_3_0 = 3;
    localparam int PIN_3_1 = 4;
    localparam int PIN_3_2 = 5;
    localparam int PIN_3_3 = 6;
    localparam int PIN_3_4 = 7;
    localparam int PIN_3_5 = 8;
    localparam int PIN_3_6 = 9;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_PIN_CFG_2_5 = 10'h030;
    localparam logic [9:0] IDX_PIN_CFG_2_6 = 10'h031;
    localparam logic [9:0] IDX_PIN_CFG_2_7 = 10'h032;
    localparam logic [9:0] IDX_PIN_CFG_3_0 = 10'h033;
    localparam logic [9:0] IDX_PIN_CFG_3_1 = 10'h034;
    localparam logic [9:0] IDX_PIN_CFG_3_2 = 10'h035;
    localparam logic [9:0] IDX_PIN_CFG_3_3 = 10'h036;
    localparam logic [9:0] IDX_PIN_CFG_3_4 = 10'h037;
    localparam logic [9:0] IDX_PIN_CFG_3_5 = 10'h038;
    localparam logic [9:0] IDX_PIN_CFG_3_6 = 10'h039;
    localparam logic [9:0] IDX_PIN_LEVEL = 10'h040;
    localparam logic [9:0] IDX_PIN_DRIVE = 10'h041;

    // Reset values and writable bit masks
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [7:0] CFG_MAIN_RESET = 8'h00;
    localparam logic [7:0] CFG_MASK_ALT = 8'h87;
    localparam logic [7:0] CFG_MASK_PLAIN = 8'h83;
    localparam logic [PIN_COUNT-1:0] DRIVE_RESET = 10'h000;

    typedef struct packed {
        logic open_drain;
        logic [3:0] reserved;
        logic alt_sel;
        logic invert;
        logic is_input;
    } gpcb_cfg_type;

    typedef struct packed {
        logic [PIN_COUNT-1:0] out;
        logic [PIN_COUNT-1:0] oe;
    } gpcb_pad_type;

endpackage

// ==== design/gpcb_bank.sv ====
// Pin configuration bank: APB registers, input filtering, pad drive.
// Assumes pads are resolved by the surroundings from out and oe.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module gpcb_bank
    import gpcb_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    // Clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic main_power_bus_reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [PIN_COUNT-1:0] pad_in,
    output gpcb_pad_type pad,
    // Alternate function sources
    input wire logic kbc_port_line_two,
    input wire logic system_mgmt_interrupt_out,
    input wire logic expansion_chip_select_two_n,
    input wire logic expansion_chip_select_three_n,
    input wire logic fan_speed_out,
    input wire logic keyboard_reset_out_n,
    // Alternate function sinks
    output logic kbc_port_line_two_sense,
    output logic rotation_pulse_input,
    output logic irq_request_a,
    output logic irq_request_b
);

    if (ADDR_WIDTH != 12) begin : g_bad_width
        $error("gpcb_bank needs a 12-bit address");
    end

    gpcb_cfg_type cfg [PIN_COUNT];
    logic [PIN_COUNT-1:0] drive;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] sync3;
    logic [PIN_COUNT-1:0] filt;
    logic [PIN_COUNT-1:0] level;
    logic [PIN_COUNT-1:0] next_level;
    logic [PIN_COUNT-1:0] alt_src;
    logic [PIN_COUNT-1:0] cfg_hit;
    logic [9:0] word_idx;
    logic aligned;
    logic level_hit;
    logic drive_hit;
    logic mapped;
    logic setup;
    logic access;
    logic wr_en;
    logic [31:0] rd_value;

    // Address decode
    assign word_idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign level_hit = aligned && (word_idx == IDX_PIN_LEVEL);
    assign drive_hit = aligned && (word_idx == IDX_PIN_DRIVE);

    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            cfg_hit[i] = aligned && (word_idx == IDX_PIN_CFG_2_5 + 10'(i));
        end
    end

    assign mapped = (|cfg_hit) || level_hit || drive_hit;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign wr_en = access && pwrite && mapped && pstrb[0];

    // Read mux; reserved bits are already zero in the registers
    always_comb begin
        rd_value = 32'h0000_0000;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (cfg_hit[i]) begin
                rd_value = {24'h00_0000, cfg[i]};
            end
        end
        if (level_hit) begin
            rd_value = {22'h00_0000, level};
        end
        if (drive_hit) begin
            rd_value = {22'h00_0000, drive};
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= rd_value;
        end
    end

    // Configuration registers
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_cfg
        localparam logic [7:0] MASK =
            (i == PIN_2_6) ? CFG_MASK_PLAIN : CFG_MASK_ALT;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg[i] <= CFG_RESET;
            end else if (i == PIN_3_3 && main_power_bus_reset) begin
                cfg[i] <= CFG_MAIN_RESET;
            end else if (wr_en && cfg_hit[i]) begin
                cfg[i] <= pwdata[7:0] & MASK;
            end
        end

        a_write_next: assert property (
            @(posedge pclk) disable iff (!presetn)
            wr_en && cfg_hit[i] && !(i == PIN_3_3 && main_power_bus_reset)
            |=> cfg[i] == ($past(pwdata[7:0]) & MASK))
            else $error("configuration write not applied");

        a_reserved_zero: assert property (
            @(posedge pclk) disable iff (!presetn)
            (cfg[i] & ~MASK) == 8'h00)
            else $error("reserved configuration bit set");

        a_reset_value: assert property (
            @(posedge pclk) disable iff (!presetn)
            $rose(presetn) |-> cfg[i] == CFG_RESET)
            else $error("configuration reset value wrong");

        a_input_no_drive: assert property (
            @(posedge pclk) disable iff (!presetn)
            cfg[i].is_input |-> !pad.oe[i])
            else $error("input pin is driven");

        a_open_drain: assert property (
            @(posedge pclk) disable iff (!presetn)
            !cfg[i].is_input && cfg[i].open_drain
            |-> !pad.out[i] && (pad.oe[i] == !((cfg[i].alt_sel ?
                alt_src[i] : drive[i]) ^ cfg[i].invert)))
            else $error("open-drain pin drives high");

        a_polarity_level: assert property (
            @(posedge pclk) disable iff (!presetn)
            ($stable(pad_in[i]) && $stable(cfg[i].invert)) [*6]
            |-> level[i] == (pad_in[i] ^ cfg[i].invert))
            else $error("pin level polarity wrong");

        a_push_pull: assert property (
            @(posedge pclk) disable iff (!presetn)
            !cfg[i].is_input && !cfg[i].open_drain
            |-> pad.oe[i] && pad.out[i] == ((cfg[i].alt_sel ?
                alt_src[i] : drive[i]) ^ cfg[i].invert))
            else $error("push-pull pin value wrong");
    end

    // Output data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive <= DRIVE_RESET;
        end else if (wr_en && drive_hit) begin
            drive <= pwdata[PIN_COUNT-1:0];
        end
    end

    // Pin input synchroniser and agreement filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pad_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt <= '0;
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (sync2[i] == sync3[i]) begin
                    filt[i] <= sync3[i];
                end
            end
        end
    end

    // Input polarity
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            next_level[i] = filt[i] ^ cfg[i].invert;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= '0;
        end else begin
            level <= next_level;
        end
    end

    // Alternate output sources
    always_comb begin
        alt_src = '0;
        alt_src[PIN_2_5] = kbc_port_line_two;
        alt_src[PIN_2_7] = system_mgmt_interrupt_out;
        alt_src[PIN_3_0] = expansion_chip_select_two_n;
        alt_src[PIN_3_1] = expansion_chip_select_three_n;
        alt_src[PIN_3_3] = fan_speed_out;
        alt_src[PIN_3_6] = keyboard_reset_out_n;
    end

    // Pad drive: direction, polarity, driver type
    always_comb begin
        logic val;
        val = 1'b0;
        pad.out = '0;
        pad.oe = '0;
        for (int i = 0; i < PIN_COUNT; i++) begin
            val = (cfg[i].alt_sel ? alt_src[i] : drive[i]) ^ cfg[i].invert;
            pad.oe[i] = !cfg[i].is_input && (!cfg[i].open_drain || !val);
            pad.out[i] = val && !cfg[i].open_drain;
        end
    end

    // Alternate input sinks
    assign kbc_port_line_two_sense = cfg[PIN_2_5].alt_sel && level[PIN_2_5];
    assign rotation_pulse_input = cfg[PIN_3_2].alt_sel && level[PIN_3_2];
    assign irq_request_a = cfg[PIN_3_4].alt_sel && level[PIN_3_4];
    assign irq_request_b = cfg[PIN_3_5].alt_sel && level[PIN_3_5];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_kbc_route: assert property (
        cfg[PIN_2_5].alt_sel && !cfg[PIN_2_5].is_input
        && !cfg[PIN_2_5].open_drain
        |-> pad.out[PIN_2_5] == (kbc_port_line_two ^ cfg[PIN_2_5].invert))
        else $error("keyboard line not routed");

    a_plain_no_alt: assert property (
        wr_en && cfg_hit[PIN_2_6] |=> !cfg[PIN_2_6].alt_sel
        && cfg[PIN_2_6].reserved == 4'h0)
        else $error("pin 2.6 took an alternate function");

    a_smi_route: assert property (
        cfg[PIN_2_7].alt_sel && !cfg[PIN_2_7].is_input
        && !cfg[PIN_2_7].open_drain && !cfg[PIN_2_7].invert
        |-> pad.out[PIN_2_7] == system_mgmt_interrupt_out)
        else $error("management interrupt not routed");

    a_cs2_route: assert property (
        cfg[PIN_3_0].alt_sel && !cfg[PIN_3_0].is_input
        && !cfg[PIN_3_0].open_drain && !cfg[PIN_3_0].invert
        |-> pad.out[PIN_3_0] == expansion_chip_select_two_n)
        else $error("chip select two not routed");

    a_cs3_route: assert property (
        cfg[PIN_3_1].alt_sel && !cfg[PIN_3_1].is_input
        && !cfg[PIN_3_1].open_drain && !cfg[PIN_3_1].invert
        |-> pad.out[PIN_3_1] == expansion_chip_select_three_n)
        else $error("chip select three not routed");

    a_tach_route: assert property (
        cfg[PIN_3_2].alt_sel && $rose(level[PIN_3_2])
        |-> rotation_pulse_input)
        else $error("rotation pulse not routed");

    a_fan_reset: assert property (
        main_power_bus_reset |=> cfg[PIN_3_3] == CFG_MAIN_RESET
        && pad.oe[PIN_3_3])
        else $error("fan pin main reset wrong");

    a_irqa_route: assert property (
        !cfg[PIN_3_4].alt_sel |-> !irq_request_a)
        else $error("request A active without its function");

    a_irqb_route: assert property (
        cfg[PIN_3_5].alt_sel && $rose(level[PIN_3_5]) |-> irq_request_b)
        else $error("request B not routed");

    a_kbdrst_route: assert property (
        cfg[PIN_3_6].alt_sel && !cfg[PIN_3_6].is_input
        && !cfg[PIN_3_6].open_drain && !cfg[PIN_3_6].invert
        |-> pad.out[PIN_3_6] == keyboard_reset_out_n)
        else $error("keyboard reset not routed");

    a_drive_write: assert property (
        wr_en && drive_hit |=> drive == $past(pwdata[PIN_COUNT-1:0]))
        else $error("output data write not applied");

    a_strobe_gate: assert property (
        access && pwrite && !pstrb[0] && cfg_hit[PIN_2_5]
        |=> $stable(cfg[PIN_2_5]))
        else $error("write without strobe applied");

    a_bad_error: assert property (
        access && !aligned |-> pslverr && !wr_en)
        else $error("misaligned access not refused");

    a_unmapped_zero: assert property (
        setup && !mapped |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_read_upper: assert property (
        setup && (|cfg_hit) |=> prdata[31:8] == 24'h00_0000)
        else $error("configuration read upper bits set");

    a_read_plain: assert property (
        setup && cfg_hit[PIN_2_6] |=> prdata[6:2] == 5'h00)
        else $error("pin 2.6 reserved bits read set");

    a_level_read: assert property (
        setup && level_hit |=> prdata == {22'h00_0000, $past(level)})
        else $error("level register read wrong");

    a_reset_inputs: assert property (
        $rose(presetn) |-> pad.oe == 10'h000)
        else $error("pin driven after reset");

    a_irqb_off: assert property (
        !cfg[PIN_3_5].alt_sel |-> !irq_request_b)
        else $error("request B active without its function");

    c_alt_write: cover property (wr_en && cfg_hit[PIN_3_3]
        && pwdata[2]);
    c_open_drain_low: cover property (pad.oe[PIN_2_5]
        && cfg[PIN_2_5].open_drain);
    c_main_reset: cover property (main_power_bus_reset);
    c_bad_address: cover property (pslverr);
    c_level_read: cover property (setup && level_hit);

endmodule
`default_nettype wire

// ==== verif/gpcb_board.sv ====
// Board model of the ten pins: pull-ups and optional outside drivers.
// Assumes the bank's pad struct and a bench that picks outside levels.
`timescale 1ns/1ps
`default_nettype none
module gpcb_board
    import gpcb_pkg::*;
(
    // Bank side
    input wire gpcb_pad_type pad,
    // Outside drivers
    input wire logic [PIN_COUNT-1:0] ext_en,
    input wire logic [PIN_COUNT-1:0] ext_lvl,
    // Resolved pin levels
    output logic [PIN_COUNT-1:0] pad_in
);
    // A released pin takes the outside level when ext_en is set, else floats up to the pull-up level
    always_comb begin
        for (int k = 0; k < PIN_COUNT; k++) begin
            pad_in[k] = pad.oe[k] ? pad.out[k] :
                (ext_en[k] ? ext_lvl[k] : 1'h1);
        end
    end
endmodule
`default_nettype wire

// ==== verif/gpcb_bank_test.sv ====
// Self-checking bench for the pin configuration bank.
// Assumes the board model and an APB master driven from here.
`timescale 1ns/1ps
`default_nettype none
module gpcb_bank_test
    import gpcb_pkg::*;
;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic main_power_bus_reset = 1'h0;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [3:0] pstrb, sink;
    logic [9:0] pad_in, ext_en, ext_lvl, drv, altv, lv;
    logic [5:0] src;
    gpcb_pad_type pad;
    logic [7:0] cfg [10];
    int num_errors = 0;
    int num_checks = 0;
    int seed = 21;
    int p;

    always #25 pclk = ~pclk;
    assign altv = {src[5], 2'h0, src[4], 1'h0, src[3:1], 1'h0, src[0]};

    gpcb_bank i_gpcb_bank (.pclk, .presetn, .main_power_bus_reset,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .pad_in, .pad,
        .kbc_port_line_two(src[0]), .system_mgmt_interrupt_out(src[1]),
        .expansion_chip_select_two_n(src[2]),
        .expansion_chip_select_three_n(src[3]),
        .fan_speed_out(src[4]), .keyboard_reset_out_n(src[5]),
        .kbc_port_line_two_sense(sink[0]),
        .rotation_pulse_input(sink[1]),
        .irq_request_a(sink[2]), .irq_request_b(sink[3]));
    gpcb_board i_gpcb_board (.pad, .ext_en, .ext_lvl, .pad_in);

    task automatic finish_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %0t reg got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_pin(input logic [9:0] g, input logic [9:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %0t pins got %h exp %h", $time, g, e);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [9:0] i,
        input logic [31:0] wd, input logic [3:0] s, input logic [1:0] lo);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {i, lo};
        pwdata <= wd;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            num_errors++;
            $display("mismatch %0t no pready", $time);
            finish_test();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask

    task automatic chk_pads();
        logic [9:0] o, e, m, s;
        logic v;
        for (int k = 0; k < 10; k++) begin
            v = (cfg[k][2] ? altv[k] : drv[k]) ^ cfg[k][1];
            e[k] = !cfg[k][0] && (!cfg[k][7] || !v);
            o[k] = v && !cfg[k][7];
            m[k] = !cfg[k][0];
            lv[k] = (e[k] ? o[k] : (ext_en[k] ? ext_lvl[k] : 1'h1));
            lv[k] = lv[k] ^ cfg[k][1];
        end
        s = {6'h0, lv[8] & cfg[8][2], lv[7] & cfg[7][2],
            lv[5] & cfg[5][2], lv[0] & cfg[0][2]};
        chk_pin(pad.oe, e);
        chk_pin(pad.out & m, o & m);
        chk_pin({6'h0, sink}, s);
    endtask

    initial begin
        {psel, penable, pwrite, pstrb, paddr, pwdata} = '0;
        {src, ext_en, ext_lvl, drv} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        for (int k = 0; k < 10; k++) begin
            cfg[k] = 8'h01;
            apb(1'h0, 10'(IDX_PIN_CFG_2_5 + k), 32'h0, 4'h0, 2'h0);
            chk_reg(rd, 32'h01);
        end
        repeat (8) @(posedge pclk);
        chk_pads();
        repeat (60) begin
            p = {$random(seed)} % 10;
            d = $random(seed);
            if ((p == PIN_3_2 || p == PIN_3_4 || p == PIN_3_5) && d[2]) begin
                d[0] = 1'h1;
            end
            cfg[p] = d[7:0] & (p == PIN_2_6 ? CFG_MASK_PLAIN : CFG_MASK_ALT);
            ext_en <= 10'($random(seed));
            ext_lvl <= 10'($random(seed));
            src <= 6'($random(seed));
            drv = 10'($random(seed));
            apb(1'h1, 10'(IDX_PIN_CFG_2_5 + p), d, 4'hf, 2'h0);
            apb(1'h1, IDX_PIN_DRIVE, {22'h0, drv}, 4'h1, 2'h0);
            repeat (8) @(posedge pclk);
            chk_pads();
            apb(1'h0, IDX_PIN_LEVEL, 32'h0, 4'h0, 2'h0);
            chk_reg(rd, {22'h0, lv});
            apb(1'h0, 10'(IDX_PIN_CFG_2_5 + p), 32'h0, 4'h0, 2'h0);
            chk_reg(rd, {24'h0, cfg[p]});
        end
        // Reserved bits, ignored strobe, then main power reset
        apb(1'h1, IDX_PIN_CFG_2_6, 32'hffffffff, 4'h1, 2'h0);
        cfg[PIN_2_6] = 8'h83;
        apb(1'h1, IDX_PIN_CFG_3_3, 32'hffffffff, 4'h1, 2'h0);
        apb(1'h1, IDX_PIN_CFG_2_5, 32'h0000007e, 4'h0, 2'h0);
        main_power_bus_reset <= 1'h1;
        @(posedge pclk);
        main_power_bus_reset <= 1'h0;
        cfg[PIN_3_3] = 8'h00;
        for (int k = 0; k < 10; k++) begin
            apb(1'h0, 10'(IDX_PIN_CFG_2_5 + k), 32'h0, 4'h0, 2'h0);
            chk_reg(rd, {24'h0, cfg[k]});
        end
        apb(1'h0, IDX_PIN_DRIVE, 32'h0, 4'h0, 2'h0);
        chk_reg(rd, {22'h0, drv});
        apb(1'h0, 10'h050, 32'h0, 4'h0, 2'h0);
        chk_reg({rd[31:1], er}, 32'h1);
        apb(1'h1, IDX_PIN_CFG_2_7, 32'h80, 4'h1, 2'h1);
        chk_reg({rd[31:1], er}, 32'h1);
        apb(1'h0, IDX_PIN_CFG_2_7, 32'h0, 4'h0, 2'h0);
        chk_reg(rd, {24'h0, cfg[PIN_2_7]});
        finish_test();
    end
endmodule
`default_nettype wire
